// file: serial_lane_sample_mapper_tb.sv
// Self-checking bench for the serial lane sample mapper.
module serial_lane_sample_mapper_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic smp_valid = 1'b0;
  logic slow = 1'b0;
  logic [6:0] mode = 7'h00;
  slsm_pkg::slsm_in_frame_type frame = '0;
  logic smp_ready, lane_valid, lane_ready, unsup;
  slsm_pkg::slsm_lanes_type lane_data;
  int errors = 0;
  int samples_checked = 0;
  int refused = 0;
  int cycles = 0;
  slsm_mapper i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .lane_mapping_mode(mode),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_frame(frame), .lane_valid(lane_valid),
    .lane_ready(lane_ready), .lane_data(lane_data), .mode_unsupported(unsup));
  slsm_link_model i_link (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .lane_ready(lane_ready));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Fills each 32-bit word differently so that no two samples of a frame repeat.
  function automatic slsm_pkg::slsm_in_frame_type mk(input int k);
    logic [447:0] v;
    for (int i = 0; i < 14; i++) begin
      v[32 * i +: 32] = 32'h9E3779B1 * (14 * k + i + 1);
    end
    return v;
  endfunction
  function automatic slsm_pkg::slsm_lanes_type exp_map(input logic [6:0] m, input int k);
    slsm_pkg::slsm_in_frame_type f;
    slsm_pkg::slsm_lanes_type l;
    logic [1:0][95:0] p;
    int n;
    f = mk(k);
    l = '0;
    p = '0;
    case (m)
      7'h10, 7'h16, 7'h2E: n = 4;
      7'h15, 7'h24: n = 2;
      7'h17, 7'h26, 7'h3D, 7'h40, 7'h45, 7'h47: n = 1;
      default: n = 0;
    endcase
    for (int i = 0; i < n; i++) begin
      l[i] = {f.ddc.chan_a_inphase[i], f.ddc.chan_a_inphase_overrange[i]};
      l[(m == 7'h10) ? 4 + i : 8 + i] =
        {f.ddc.chan_a_quadrature[i], f.ddc.chan_a_quadrature_overrange[i]};
      if (m == 7'h10) begin
        l[8 + i] = {f.ddc.chan_b_inphase[i], f.ddc.chan_b_inphase_overrange[i]};
        l[12 + i] = {f.ddc.chan_b_quadrature[i], f.ddc.chan_b_quadrature_overrange[i]};
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (m == 7'h13 || m == 7'h2A) begin
        p[0][95 - 12 * i -: 12] = f.byp[2 * i];
        p[1][95 - 12 * i -: 12] = f.byp[2 * i + 1];
      end
      if (m == 7'h14 || m == 7'h2B) begin
        p[0][95 - 12 * i -: 12] = f.byp[i];
        p[1][95 - 12 * i -: 12] = f.byp[8 + i];
      end
    end
    for (int j = 0; j < 6; j++) begin
      l[j] = l[j] | p[0][95 - 16 * j -: 16];
      l[8 + j] = l[8 + j] | p[1][95 - 16 * j -: 16];
    end
    return l;
  endfunction
  task automatic send(input logic [6:0] m, input int k);
    mode = m;
    frame = mk(k);
    smp_valid = 1'b1;
    for (int n = 0; n < 50 && smp_ready !== 1'b1; n++) begin
      refused++;
      @(negedge core_clk);
    end
    check({255'h0, smp_ready}, 256'h1);
    @(negedge core_clk);
  endtask
  task automatic recv(input logic [6:0] m, input int k);
    for (int n = 0; n < 50 && (lane_valid && lane_ready) !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    check({255'h0, lane_valid && lane_ready}, 256'h1);
    check(lane_data, exp_map(m, k));
    @(negedge core_clk);
  endtask
  task automatic t_all_modes();
    logic [6:0] modes [18] = '{7'h10, 7'h13, 7'h2A, 7'h14, 7'h2B, 7'h15, 7'h24, 7'h16,
      7'h2E, 7'h17, 7'h26, 7'h3D, 7'h40, 7'h45, 7'h47, 7'h00, 7'h11, 7'h7F};
    foreach (modes[j]) begin
      fork
        begin
          send(modes[j], j);
          smp_valid = 1'b0;
        end
        recv(modes[j], j);
      join
      check({255'h0, unsup}, {255'h0, j > 14});
    end
  endtask
  task automatic t_backpressure();
    slow = 1'b1;
    fork
      begin
        for (int i = 0; i < 6; i++) send((i % 2) ? 7'h10 : 7'h14, 20 + i);
        smp_valid = 1'b0;
      end
      for (int i = 0; i < 6; i++) recv((i % 2) ? 7'h10 : 7'h14, 20 + i);
    join
    check({255'h0, refused > 0}, {255'h0, 1'b1});
    check({255'h0, lane_valid}, 256'h0);
    slow = 1'b0;
  endtask
  task automatic t_reset_mid();
    slow = 1'b1;
    send(7'h10, 40);
    smp_valid = 1'b0;
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    check({254'h0, smp_ready, lane_valid}, {254'h0, 2'h2});
    slow = 1'b0;
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    t_all_modes();
    t_backpressure();
    t_reset_mid();
    t_all_modes();
    report_and_stop();
  end
endmodule

// file: slsm_buf2.sv
// Two-entry buffer with valid and ready on both sides.
module slsm_buf2 #(
  parameter int WIDTH = 256
) (
  input wire logic core_clk, // Clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [WIDTH-1:0] in_data, // Word in.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Receiver takes the word.
  output logic [WIDTH-1:0] out_data // Word out.
);

  logic [WIDTH-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rd_ptr_r];
  assign count_nxt = count_r + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r <= count_nxt;
    end
  end

endmodule

// file: slsm_link_model.sv
// Link layer stand-in that takes lane frames promptly or one cycle in four.
module slsm_link_model (
  input wire logic core_clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic slow, // Stall mode.
  output logic lane_ready // Take.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r;
  always_ff @(posedge core_clk) begin
    cnt_r <= sys_rst ? 2'h0 : cnt_r + 2'h1;
    lane_ready <= !sys_rst && (!slow || cnt_r == 2'h3);
  end
endmodule

// file: slsm_mapper.sv
// Transport-layer mapper that places converter samples onto the serial lanes.
module slsm_mapper (
  input wire logic core_clk, // Frame clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [slsm_pkg::MODE_W-1:0] lane_mapping_mode, // Mapping mode.
  input wire logic smp_valid, // Sample frame offered.
  output logic smp_ready, // Sample frame accepted.
  input wire slsm_pkg::slsm_in_frame_type smp_frame, // Sample frame.
  output logic lane_valid, // Lane frame available.
  input wire logic lane_ready, // Link layer takes the lane frame.
  output slsm_pkg::slsm_lanes_type lane_data, // Lane words, 0-7 A, 8-15 B.
  output logic mode_unsupported // Mode has no mapping here.
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [slsm_pkg::LANE_W-1:0] dec_word(
    input logic [slsm_pkg::DEC_W-1:0] smp,
    input logic ovr
  );
    logic [slsm_pkg::LANE_W-1:0] w;
    w = {smp, 1'b0};
    w[slsm_pkg::OR_POS] = ovr; // [R9] [R10]
    return w;
  endfunction

  // Packs eight samples MSB first and back to back into six lanes.
  function automatic logic [slsm_pkg::PACK_W-1:0] pack8(
    input slsm_pkg::slsm_byp_frame_type s,
    input int first,
    input int step
  );
    logic [slsm_pkg::PACK_W-1:0] p;
    p = '0;
    for (int k = 0; k < slsm_pkg::PACK_SAMPLES; k++) begin
      p[slsm_pkg::PACK_W-1-k*slsm_pkg::BYP_W -: slsm_pkg::BYP_W] = s[first+k*step]; // [R3]
    end
    return p;
  endfunction

  function automatic slsm_pkg::slsm_mode_class_type classify(
    input logic [slsm_pkg::MODE_W-1:0] m
  );
    slsm_pkg::slsm_mode_class_type c;
    c = slsm_pkg::SLSM_MC_NONE;
    if (m == slsm_pkg::MODE_D8_DUAL_16) begin
      c = slsm_pkg::SLSM_MC_D8_DUAL_16;
    end else if (m == slsm_pkg::MODE_BYP_SINGLE_0 || m == slsm_pkg::MODE_BYP_SINGLE_1) begin
      c = slsm_pkg::SLSM_MC_BYP_SINGLE;
    end else if (m == slsm_pkg::MODE_BYP_DUAL_0 || m == slsm_pkg::MODE_BYP_DUAL_1) begin
      c = slsm_pkg::SLSM_MC_BYP_DUAL;
    end else if (m == slsm_pkg::MODE_D4_SINGLE_4_0 || m == slsm_pkg::MODE_D4_SINGLE_4_1) begin
      c = slsm_pkg::SLSM_MC_D4_SINGLE_4;
    end else if (m == slsm_pkg::MODE_D4_SINGLE_8_0 || m == slsm_pkg::MODE_D4_SINGLE_8_1) begin
      c = slsm_pkg::SLSM_MC_D4_SINGLE_8;
    end else if (m == slsm_pkg::MODE_D8_SINGLE_2_0 || m == slsm_pkg::MODE_D8_SINGLE_2_1 ||
                 m == slsm_pkg::MODE_D8_SINGLE_2_2 || m == slsm_pkg::MODE_D8_SINGLE_2_3 ||
                 m == slsm_pkg::MODE_D8_SINGLE_2_4 || m == slsm_pkg::MODE_D8_SINGLE_2_5) begin
      c = slsm_pkg::SLSM_MC_D8_SINGLE_2;
    end
    return c;
  endfunction

  // ****************************************************************
  // Per-mode lane sets
  // ****************************************************************
  slsm_pkg::slsm_ddc_frame_type ddc;
  slsm_pkg::slsm_mode_class_type mode_class;
  slsm_pkg::slsm_lanes_type lanes_d8_dual;
  slsm_pkg::slsm_lanes_type lanes_byp;
  slsm_pkg::slsm_lanes_type lanes_single;
  slsm_pkg::slsm_lanes_type lanes_map;
  logic [slsm_pkg::PACK_W-1:0] pack_a;
  logic [slsm_pkg::PACK_W-1:0] pack_b;
  logic [slsm_pkg::DEC_SAMPLES-1:0][slsm_pkg::LANE_W-1:0] ai_w, aq_w, bi_w, bq_w;
  logic [2:0] single_count;

  assign ddc = smp_frame.ddc;
  assign mode_class = classify(lane_mapping_mode);
  assign mode_unsupported = (mode_class == slsm_pkg::SLSM_MC_NONE);

  genvar g;
  generate
    for (g = 0; g < slsm_pkg::DEC_SAMPLES; g++) begin : g_dec
      assign ai_w[g] = dec_word(ddc.chan_a_inphase[g], ddc.chan_a_inphase_overrange[g]);
      assign aq_w[g] = dec_word(ddc.chan_a_quadrature[g], ddc.chan_a_quadrature_overrange[g]);
      assign bi_w[g] = dec_word(ddc.chan_b_inphase[g], ddc.chan_b_inphase_overrange[g]);
      assign bq_w[g] = dec_word(ddc.chan_b_quadrature[g], ddc.chan_b_quadrature_overrange[g]);
      assign lanes_d8_dual[g] = ai_w[g]; // [R1]
      assign lanes_d8_dual[g+slsm_pkg::DEC_SAMPLES] = aq_w[g]; // [R1]
      assign lanes_d8_dual[g+slsm_pkg::GROUP_LANES] = bi_w[g]; // [R2]
      assign lanes_d8_dual[g+slsm_pkg::GROUP_LANES+slsm_pkg::DEC_SAMPLES] = bq_w[g]; // [R2]
      // In-phase on group A, quadrature on group B, count set by the mode.
      assign lanes_single[g] = (g < single_count) ? ai_w[g] : '0; // [R6] [R7] [R8]
      assign lanes_single[g+slsm_pkg::GROUP_LANES] = (g < single_count) ? aq_w[g] : '0;
      assign lanes_single[g+slsm_pkg::DEC_SAMPLES] = '0;
      assign lanes_single[g+slsm_pkg::GROUP_LANES+slsm_pkg::DEC_SAMPLES] = '0;
    end
  endgenerate

  assign single_count = (mode_class == slsm_pkg::SLSM_MC_D4_SINGLE_8) ? 3'h4 : // [R7]
                        (mode_class == slsm_pkg::SLSM_MC_D4_SINGLE_4) ? 3'h2 : // [R6]
                        3'h1; // [R8]

  // Single channel splits even and odd samples; dual channel takes A then B.
  assign pack_a = (mode_class == slsm_pkg::SLSM_MC_BYP_SINGLE) ?
                  pack8(smp_frame.byp, 0, 2) : pack8(smp_frame.byp, 0, 1); // [R4] [R5]
  assign pack_b = (mode_class == slsm_pkg::SLSM_MC_BYP_SINGLE) ?
                  pack8(smp_frame.byp, 1, 2) :
                  pack8(smp_frame.byp, slsm_pkg::PACK_SAMPLES, 1); // [R4] [R5]

  generate
    for (g = 0; g < slsm_pkg::GROUP_LANES; g++) begin : g_byp
      if (g < slsm_pkg::PACK_LANES) begin : g_used
        assign lanes_byp[g] = pack_a[slsm_pkg::PACK_W-1-g*slsm_pkg::LANE_W -: slsm_pkg::LANE_W]; // [R3]
        assign lanes_byp[g+slsm_pkg::GROUP_LANES] =
          pack_b[slsm_pkg::PACK_W-1-g*slsm_pkg::LANE_W -: slsm_pkg::LANE_W]; // [R3]
      end else begin : g_idle
        assign lanes_byp[g] = '0;
        assign lanes_byp[g+slsm_pkg::GROUP_LANES] = '0;
      end
    end
  endgenerate

  assign lanes_map = (mode_class == slsm_pkg::SLSM_MC_D8_DUAL_16) ? lanes_d8_dual :
                     (mode_class == slsm_pkg::SLSM_MC_BYP_SINGLE ||
                      mode_class == slsm_pkg::SLSM_MC_BYP_DUAL) ? lanes_byp :
                     (mode_class == slsm_pkg::SLSM_MC_NONE) ? '0 : lanes_single;

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  slsm_buf2 #(
    .WIDTH(slsm_pkg::LANES * slsm_pkg::LANE_W)
  ) u_buf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(lanes_map),
    .out_valid(lane_valid),
    .out_ready(lane_ready),
    .out_data(lane_data)
  );

endmodule

// file: slsm_mapper_checker.sv
// Port checker for the serial lane sample mapper.
module slsm_mapper_checker (
  input wire logic core_clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic [slsm_pkg::MODE_W-1:0] lane_mapping_mode, // Mode.
  input wire logic smp_valid, // Offer.
  input wire logic smp_ready, // Room.
  input wire slsm_pkg::slsm_in_frame_type smp_frame, // Frame.
  input wire logic lane_valid, // Lanes offered.
  input wire logic lane_ready, // Lanes taken.
  input wire slsm_pkg::slsm_lanes_type lane_data // Lanes.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  slsm_pkg::slsm_in_frame_type f;
  logic t;
  assign t = smp_valid && smp_ready && !lane_valid;
  always_ff @(posedge core_clk) f <= smp_frame;
  a_reset_state: assert property ($fell(sys_rst) |-> smp_ready && !lane_valid)
    else $error("bad state after reset");
  a_answer_next: assert property (t |=> lane_valid) else $error("lane frame late");
  a_stall_hold: assert property (lane_valid && !lane_ready |=> lane_valid && $stable(lane_data))
    else $error("stalled lane frame moved");
  a_full_refuse: assert property (lane_valid && !lane_ready && smp_valid && smp_ready
    |=> !smp_ready) else $error("third frame accepted");
  a_dual_ddc_map:
    assert property (t && lane_mapping_mode == 7'h10 |=> lane_data[4] ==
      {f.ddc.chan_a_quadrature[0], f.ddc.chan_a_quadrature_overrange[0]} && lane_data[15] ==
      {f.ddc.chan_b_quadrature[3], f.ddc.chan_b_quadrature_overrange[3]}) else $error("mode 16");
  a_dual_byp_pack:
    assert property (t && lane_mapping_mode == 7'h14 |=> lane_data[2] ==
      {f.byp[2][3:0], f.byp[3]} && lane_data[13] == {f.byp[14][3:0], f.byp[15]})
      else $error("dual bypass");
  a_single_byp_split:
    assert property (t && lane_mapping_mode == 7'h13 |=> lane_data[9] ==
      {f.byp[3][7:0], f.byp[5][11:4]} && lane_data[0] == {f.byp[0], f.byp[2][11:8]})
      else $error("single bypass");
  a_two_lane_map:
    assert property (t && lane_mapping_mode == 7'h17 |=> lane_data[1] == 16'h0000 &&
      lane_data[8] == {f.ddc.chan_a_quadrature[0], f.ddc.chan_a_quadrature_overrange[0]})
      else $error("two lane");
endmodule

bind slsm_mapper slsm_mapper_checker i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .lane_mapping_mode(lane_mapping_mode), .smp_valid(smp_valid), .smp_ready(smp_ready),
  .smp_frame(smp_frame), .lane_valid(lane_valid), .lane_ready(lane_ready),
  .lane_data(lane_data));

// file: slsm_pkg.sv
// Constants, types and mode codes for the serial lane sample mapper.
//
// Summary of operation
// [R1] Mode 16: A I/Q samples on A lanes 0-7.
// [R2] Mode 16: B I/Q samples on B lanes 0-7.
// [R3] Bypass 12-bit samples packed MSB first, back to back.
// [R4] Single bypass: even samples A, odd samples B.
// [R5] Dual bypass: A samples A lanes, B samples B.
// [R6] Modes 21/36: I and Q on two lanes each.
// [R7] Modes 22/46: I and Q on four lanes each.
// [R8] Decimate-by-8 two lanes: I A0, Q B0.
// [R9] Decimated lane word: 15-bit sample plus overrange.
// [R10] Overrange bit in the lane word LSB.
package slsm_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int LANES = 16;
  localparam int GROUP_LANES = 8;
  localparam int LANE_W = 16;
  localparam int DEC_W = 15;
  localparam int BYP_W = 12;
  localparam int BYP_SAMPLES = 16;
  localparam int DEC_SAMPLES = 4;
  localparam int PACK_SAMPLES = 8;
  localparam int PACK_W = PACK_SAMPLES * BYP_W;
  localparam int PACK_LANES = PACK_W / LANE_W;
  localparam int MODE_W = 7;
  localparam int OR_POS = 0;

  // ****************************************************************
  // Mapping mode codes
  // ****************************************************************
  localparam logic [6:0] MODE_D8_DUAL_16 = 7'h10;
  localparam logic [6:0] MODE_BYP_SINGLE_0 = 7'h13;
  localparam logic [6:0] MODE_BYP_SINGLE_1 = 7'h2A;
  localparam logic [6:0] MODE_BYP_DUAL_0 = 7'h14;
  localparam logic [6:0] MODE_BYP_DUAL_1 = 7'h2B;
  localparam logic [6:0] MODE_D4_SINGLE_4_0 = 7'h15;
  localparam logic [6:0] MODE_D4_SINGLE_4_1 = 7'h24;
  localparam logic [6:0] MODE_D4_SINGLE_8_0 = 7'h16;
  localparam logic [6:0] MODE_D4_SINGLE_8_1 = 7'h2E;
  localparam logic [6:0] MODE_D8_SINGLE_2_0 = 7'h17;
  localparam logic [6:0] MODE_D8_SINGLE_2_1 = 7'h26;
  localparam logic [6:0] MODE_D8_SINGLE_2_2 = 7'h3D;
  localparam logic [6:0] MODE_D8_SINGLE_2_3 = 7'h40;
  localparam logic [6:0] MODE_D8_SINGLE_2_4 = 7'h45;
  localparam logic [6:0] MODE_D8_SINGLE_2_5 = 7'h47;

  typedef enum logic [2:0] {
    SLSM_MC_NONE = 3'b000,
    SLSM_MC_D8_DUAL_16 = 3'b001,
    SLSM_MC_BYP_SINGLE = 3'b010,
    SLSM_MC_BYP_DUAL = 3'b011,
    SLSM_MC_D4_SINGLE_4 = 3'b100,
    SLSM_MC_D4_SINGLE_8 = 3'b101,
    SLSM_MC_D8_SINGLE_2 = 3'b110
  } slsm_mode_class_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  // Decimated samples; single-channel modes use the channel A fields
  // as in-phase and quadrature.
  typedef struct packed {
    logic [DEC_SAMPLES-1:0][DEC_W-1:0] chan_a_inphase;
    logic [DEC_SAMPLES-1:0][DEC_W-1:0] chan_a_quadrature;
    logic [DEC_SAMPLES-1:0][DEC_W-1:0] chan_b_inphase;
    logic [DEC_SAMPLES-1:0][DEC_W-1:0] chan_b_quadrature;
    logic [DEC_SAMPLES-1:0] chan_a_inphase_overrange;
    logic [DEC_SAMPLES-1:0] chan_a_quadrature_overrange;
    logic [DEC_SAMPLES-1:0] chan_b_inphase_overrange;
    logic [DEC_SAMPLES-1:0] chan_b_quadrature_overrange;
  } slsm_ddc_frame_type;

  // Bypass samples; dual-channel modes hold channel A in slots 0-7 and
  // channel B in slots 8-15.
  typedef logic [BYP_SAMPLES-1:0][BYP_W-1:0] slsm_byp_frame_type;

  typedef struct packed {
    slsm_ddc_frame_type ddc;
    slsm_byp_frame_type byp;
  } slsm_in_frame_type;

  // Lanes 0-7 are group A, lanes 8-15 are group B.
  typedef logic [LANES-1:0][LANE_W-1:0] slsm_lanes_type;

endpackage
